/* core/spio_sensor_pad_io_control.sv */
// Summary of operation
// RQ1 - Drive field selects 1x to 4x strength
// RQ2 - Direction bit 7 sets frame sync pad
// RQ3 - Direction bit 6 sets line valid pad
// RQ4 - Direction bit 4 sets exposure trigger pad
// RQ5 - Direction bit 3 sets frame sync input
// RQ6 - Direction bit 0 sets general pad a
// RQ7 - Direction bit 1 sets general pad b
// RQ8 - Select bit 7: vsync or level bit 7
// RQ9 - Select bit 6: hsync or level bit 6
// RQ10 - Select bit 5: path or level bit 4
// RQ11 - Select bit 4: flash path or bit 2
// RQ12 - Select bit 3: illumination or level bit 3
// RQ13 - Select bit 0: path or level bit 0
// RQ14 - Select bit 1: path or level bit 1
// RQ15 - Level register holds one bit per pad
// RQ16 - Lanes float in reset, high afterwards
// RQ17 - Frame sync: float, input, standby float
// RQ18 - Reference clock input except hardware standby
// RQ19 - Hardware reset restores every register default
// RQ20 - Flash pad drives zero by default
// RQ21 - Hardware standby keeps all register contents
// RQ22 - Input direction never drives the pad
// RQ23 - Unused register bits affect no pad
`timescale 1ns/1ns
`include "spio_defines.svh"

module spio_sensor_pad_io_control
	import spio_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   standbyN,
	input  wire logic                   softStandby,
	input  wire spio_pkg::spio_addr_type regAddr,
	input  wire logic                   regWrite,
	input  wire logic                   regRead,
	input  wire spio_pkg::spio_byte_type regWriteData,
	output spio_pkg::spio_byte_type      regReadData,
	output logic                        regReadValid,
	output spio_pkg::spio_drive_type     driveStrength,
	input  wire logic                   vsyncPath,
	input  wire logic                   hsyncPath,
	input  wire logic                   exposurePath,
	input  wire logic                   illuminationPath,
	input  wire logic                   flashPath,
	input  wire logic                   gpioPathA,
	input  wire logic                   gpioPathB,
	input  wire logic                   frameSyncPadIn,
	output logic                        frameSyncPadOut,
	output logic                        frameSyncPadOe,
	input  wire logic                   lineValidPadIn,
	output logic                        lineValidPadOut,
	output logic                        lineValidPadOe,
	input  wire logic                   exposureTriggerPadIn,
	output logic                        exposureTriggerPadOut,
	output logic                        exposureTriggerPadOe,
	input  wire logic                   frameSyncInPadIn,
	output logic                        frameSyncInPadOut,
	output logic                        frameSyncInPadOe,
	input  wire logic                   generalIoPadAIn,
	output logic                        generalIoPadAOut,
	output logic                        generalIoPadAOe,
	input  wire logic                   generalIoPadBIn,
	output logic                        generalIoPadBOut,
	output logic                        generalIoPadBOe,
	output logic                        flashTriggerPadOut,
	output logic                        flashTriggerPadOe,
	output logic                        illuminationPwmPadOut,
	output logic                        illuminationPwmPadOe,
	output logic [9:0]                  lanePadOut,
	output logic [9:0]                  lanePadOe,
	output logic                        refClockInEnable
);

	import spio_pkg::*;

	// ***************************************************************
	// Register file
	// ***************************************************************
	spio_byte_type padDirection;
	spio_byte_type padLevel;
	spio_byte_type padSource;
	spio_byte_type padDrive;
	spio_byte_type padStandby;
	spio_byte_type next_padDirection;
	spio_byte_type next_padLevel;
	spio_byte_type next_padSource;
	spio_byte_type next_padDrive;
	spio_byte_type next_padStandby;
	spio_byte_type next_regReadData;
	spio_byte_type padInputs;

	assign padInputs = {frameSyncPadIn, lineValidPadIn, 1'b0, exposureTriggerPadIn,
		frameSyncInPadIn, 1'b0, generalIoPadBIn, generalIoPadAIn};

	always_comb begin
		next_padDirection = padDirection;
		next_padLevel     = padLevel;
		next_padSource    = padSource;
		next_padDrive     = padDrive;
		next_padStandby   = padStandby;
		// RQ23 reserved bits masked
		if (regWrite) begin
			if (regAddr == `SPIO_OFF_DIRECTION) begin
				next_padDirection = regWriteData & `SPIO_MASK_DIRECTION;
			end else if (regAddr == `SPIO_OFF_LEVEL) begin
				next_padLevel = regWriteData & `SPIO_MASK_LEVEL;
			end else if (regAddr == `SPIO_OFF_SOURCE) begin
				next_padSource = regWriteData & `SPIO_MASK_SOURCE;
			end else if (regAddr == `SPIO_OFF_DRIVE) begin
				next_padDrive = regWriteData & `SPIO_MASK_DRIVE;
			end else if (regAddr == `SPIO_OFF_STANDBY) begin
				next_padStandby = regWriteData & `SPIO_MASK_STANDBY;
			end
		end
	end

	always_comb begin
		next_regReadData = 8'h00;
		if (regAddr == `SPIO_OFF_DIRECTION) begin
			next_regReadData = padDirection;
		end else if (regAddr == `SPIO_OFF_LEVEL) begin
			next_regReadData = padLevel;
		end else if (regAddr == `SPIO_OFF_SOURCE) begin
			next_regReadData = padSource;
		end else if (regAddr == `SPIO_OFF_DRIVE) begin
			next_regReadData = padDrive;
		end else if (regAddr == `SPIO_OFF_STANDBY) begin
			next_regReadData = padStandby;
		end else if (regAddr == `SPIO_OFF_PAD_INPUT) begin
			next_regReadData = padInputs;
		end
	end

	// RQ21 standby does not touch registers
	always_ff @(posedge clk) begin
		// RQ19 reset restores defaults
		if (!resetn) begin
			padDirection <= `SPIO_RST_DIRECTION;
			padLevel     <= `SPIO_RST_LEVEL;
			padSource    <= `SPIO_RST_SOURCE;
			padDrive     <= `SPIO_RST_DRIVE;
			padStandby   <= `SPIO_RST_STANDBY;
			regReadData  <= 8'h00;
			regReadValid <= 1'b0;
		end else begin
			padDirection <= next_padDirection;
			padLevel     <= next_padLevel;
			padSource    <= next_padSource;
			padDrive     <= next_padDrive;
			padStandby   <= next_padStandby;
			regReadData  <= regRead ? next_regReadData : regReadData;
			regReadValid <= regRead;
		end
	end

	// RQ1 drive strength field
	assign driveStrength = padDrive[`SPIO_DRIVE_MSB:`SPIO_DRIVE_LSB];

	// ***************************************************************
	// Operating mode
	// ***************************************************************
	spio_mode_type mode;
	spio_mode_type next_mode;

	always_comb begin
		case ({standbyN, softStandby})
			2'b10:   next_mode = SPIO_RUN;
			2'b11:   next_mode = SPIO_SOFT_STANDBY;
			default: next_mode = SPIO_HARD_STANDBY;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode <= SPIO_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	logic standbyActive;
	assign standbyActive = (mode != SPIO_RUN);

	// ***************************************************************
	// Bidirectional pads
	// ***************************************************************
	// Order: frame, line, exposure, sync in, gpio b, gpio a
	logic [5:0] cellDir;
	logic [5:0] cellSel;
	logic [5:0] cellLevel;
	logic [5:0] cellPath;
	logic [5:0] cellOut;
	logic [5:0] cellOe;

	// RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 direction bits
	assign cellDir = {padDirection[`SPIO_BIT_FRAME], padDirection[`SPIO_BIT_LINE],
		padDirection[`SPIO_BIT_EXPO], padDirection[`SPIO_BIT_SYNC_IN],
		padDirection[`SPIO_BIT_GPIO_B], padDirection[`SPIO_BIT_GPIO_A]};
	// RQ8 RQ9 RQ10 RQ12 RQ13 RQ14 source select
	assign cellSel = {padSource[`SPIO_BIT_FRAME], padSource[`SPIO_BIT_LINE],
		padSource[`SPIO_BIT_EXPO_SEL], padSource[`SPIO_BIT_SYNC_IN],
		padSource[`SPIO_BIT_GPIO_B], padSource[`SPIO_BIT_GPIO_A]};
	// RQ15 per pad levels
	assign cellLevel = {padLevel[`SPIO_BIT_FRAME], padLevel[`SPIO_BIT_LINE],
		padLevel[`SPIO_BIT_EXPO], padLevel[`SPIO_BIT_SYNC_IN],
		padLevel[`SPIO_BIT_GPIO_B], padLevel[`SPIO_BIT_GPIO_A]};
	assign cellPath = {vsyncPath, hsyncPath, exposurePath, illuminationPath,
		gpioPathB, gpioPathA};

	// RQ17 float in reset, and in standby unless the padStandby keep bit is set
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_cell
			spio_pad_cell u_cell (
				.clk           (clk),
				.resetn        (resetn),
				.standbyActive (standbyActive),
				.keepInStandby (padStandby[`SPIO_SB_PADS_KEEP]),
				.dirOut        (cellDir[gi]),
				.selRegister   (cellSel[gi]),
				.regLevel      (cellLevel[gi]),
				.pathLevel     (cellPath[gi]),
				.padOut        (cellOut[gi]),
				.padOe         (cellOe[gi])
			);
		end
	endgenerate

	assign frameSyncPadOut       = cellOut[5];
	assign frameSyncPadOe        = cellOe[5];
	assign lineValidPadOut       = cellOut[4];
	assign lineValidPadOe        = cellOe[4];
	assign exposureTriggerPadOut = cellOut[3];
	assign exposureTriggerPadOe  = cellOe[3];
	assign frameSyncInPadOut     = cellOut[2];
	assign frameSyncInPadOe      = cellOe[2];
	assign generalIoPadBOut      = cellOut[1];
	assign generalIoPadBOe       = cellOe[1];
	assign generalIoPadAOut      = cellOut[0];
	assign generalIoPadAOe       = cellOe[0];

	// ***************************************************************
	// Output-only pads
	// ***************************************************************
	logic flashLevel;
	logic next_flashLevel;
	logic pwmLevel;
	logic next_pwmLevel;

	always_comb begin
		// RQ11 flash source select
		next_flashLevel = padSource[`SPIO_BIT_FLASH_SEL] ?
			padLevel[`SPIO_BIT_FLASH_VAL] : flashPath;
		// RQ20 zero in standby by default
		if (standbyActive && !padStandby[`SPIO_SB_FLASH_KEEP]) begin
			next_flashLevel = 1'b0;
		end
		// Illumination zero while any standby holds
		next_pwmLevel = standbyActive ? 1'b0 : illuminationPath;
	end

	always_ff @(posedge clk) begin
		// RQ20 flash zero in reset
		if (!resetn) begin
			flashLevel <= 1'b0;
			pwmLevel   <= 1'b0;
		end else begin
			flashLevel <= next_flashLevel;
			pwmLevel   <= next_pwmLevel;
		end
	end

	// Always driven, so never floats between modes
	assign flashTriggerPadOut    = flashLevel;
	assign flashTriggerPadOe     = 1'b1;
	assign illuminationPwmPadOut = pwmLevel;
	assign illuminationPwmPadOe  = 1'b1;

	// ***************************************************************
	// Lane pads and reference clock
	// ***************************************************************
	spio_lane_idle u_lane (
		.clk               (clk),
		.resetn            (resetn),
		.mode              (mode),
		.laneHighInStandby (padStandby[`SPIO_SB_LANE_HIGH]),
		.laneOut           (lanePadOut),
		.laneOe            (lanePadOe)
	);

	// RQ18 clock input off in hardware standby
	assign refClockInEnable = standbyN;

endmodule : spio_sensor_pad_io_control

/* include/spio_defines.svh */
`ifndef SPIO_DEFINES_SVH
`define SPIO_DEFINES_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define SPIO_OFF_DIRECTION    16'h3002
`define SPIO_OFF_LEVEL        16'h3005
`define SPIO_OFF_SOURCE       16'h3008
`define SPIO_OFF_DRIVE        16'h3009
`define SPIO_OFF_STANDBY      16'h30F0
`define SPIO_OFF_PAD_INPUT    16'h30F1

// ***************************************************************
// Implemented bits, the rest read zero
// ***************************************************************
`define SPIO_MASK_DIRECTION   8'hDB
`define SPIO_MASK_LEVEL       8'hDF
`define SPIO_MASK_SOURCE      8'hFB
`define SPIO_MASK_DRIVE       8'h60
`define SPIO_MASK_STANDBY     8'h07

// ***************************************************************
// Reset values
// ***************************************************************
`define SPIO_RST_DIRECTION    8'h00
`define SPIO_RST_LEVEL        8'h00
`define SPIO_RST_SOURCE       8'h00
`define SPIO_RST_DRIVE        8'h00
`define SPIO_RST_STANDBY      8'h01

// ***************************************************************
// Field positions
// ***************************************************************
`define SPIO_DRIVE_LSB        5
`define SPIO_DRIVE_MSB        6
`define SPIO_SB_LANE_HIGH     0
`define SPIO_SB_PADS_KEEP     1
`define SPIO_SB_FLASH_KEEP    2
`define SPIO_BIT_FRAME        7
`define SPIO_BIT_LINE         6
`define SPIO_BIT_EXPO_SEL     5
`define SPIO_BIT_EXPO         4
`define SPIO_BIT_FLASH_SEL    4
`define SPIO_BIT_SYNC_IN      3
`define SPIO_BIT_FLASH_VAL    2
`define SPIO_BIT_GPIO_B       1
`define SPIO_BIT_GPIO_A       0

`endif

/* include/spio_pkg.sv */
package spio_pkg;

	// Gray coded along run, soft standby, hard standby
	typedef enum logic [1:0] {
		SPIO_RUN          = 2'b00,
		SPIO_SOFT_STANDBY = 2'b01,
		SPIO_HARD_STANDBY = 2'b11
	} spio_mode_type;

	typedef logic [7:0]  spio_byte_type;
	typedef logic [15:0] spio_addr_type;
	typedef logic [1:0]  spio_drive_type;

endpackage : spio_pkg

/* core/spio_pad_cell.sv */
`timescale 1ns/1ns

module spio_pad_cell
	import spio_pkg::*;
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic standbyActive,
	input  wire logic keepInStandby,
	input  wire logic dirOut,
	input  wire logic selRegister,
	input  wire logic regLevel,
	input  wire logic pathLevel,
	output logic      padOut,
	output logic      padOe
);

	logic next_padOut;
	logic next_padOe;

	always_comb begin
		// RQ22 input never driven
		next_padOe  = dirOut;
		next_padOut = selRegister ? regLevel : pathLevel;
		// Standby floats the pad unless software asked to keep it
		if (standbyActive && !keepInStandby) begin
			next_padOe = 1'b0;
		end
		if (!next_padOe) begin
			next_padOut = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			padOut <= 1'b0;
			padOe  <= 1'b0;
		end else begin
			padOut <= next_padOut;
			padOe  <= next_padOe;
		end
	end

endmodule : spio_pad_cell

/* core/spio_lane_idle.sv */
`timescale 1ns/1ns

module spio_lane_idle
	import spio_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire spio_mode_type mode,
	input  wire logic          laneHighInStandby,
	output logic [9:0]         laneOut,
	output logic [9:0]         laneOe
);

	logic next_drive;
	logic driveHigh;

	always_comb begin
		// RQ16 lanes high after release
		next_drive = 1'b1;
		if (mode != SPIO_RUN) begin
			next_drive = laneHighInStandby;
		end
	end

	always_ff @(posedge clk) begin
		// RQ16 lanes float in reset
		if (!resetn) begin
			driveHigh <= 1'b0;
		end else begin
			driveHigh <= next_drive;
		end
	end

	assign laneOut = {10{driveHigh}};
	assign laneOe  = {10{driveHigh}};

endmodule : spio_lane_idle

/* verification/spio_pad_monitor.sv */
`timescale 1ns/1ns

// ********************************
// Pad behaviour checker
// ********************************
module spio_pad_monitor
	import spio_pkg::*;
(
	input logic                    clk,
	input logic                    resetn,
	input logic                    standbyN,
	input logic                    softStandby,
	input spio_pkg::spio_addr_type regAddr,
	input logic                    regWrite,
	input spio_pkg::spio_byte_type regWriteData,
	input spio_pkg::spio_drive_type driveStrength,
	input logic                    vsyncPath,
	input logic                    hsyncPath,
	input logic                    exposurePath,
	input logic                    gpioPathB,
	input logic                    frameSyncPadOut,
	input logic                    frameSyncPadOe,
	input logic                    lineValidPadOut,
	input logic                    exposureTriggerPadOut,
	input logic                    generalIoPadBOut,
	input logic                    flashTriggerPadOut,
	input logic                    flashTriggerPadOe,
	input logic [9:0]              lanePadOut,
	input logic [9:0]              lanePadOe,
	input logic                    refClockInEnable
);
	spio_byte_type dirShadow, srcShadow, lvlShadow, drvShadow;
	spio_byte_type next_dirShadow, next_srcShadow, next_lvlShadow, next_drvShadow;
	logic          runQ, next_runQ;

	// Shadow copies, so pad checks need no view of the bodies
	always_comb begin
		next_dirShadow = dirShadow;
		next_srcShadow = srcShadow;
		next_lvlShadow = lvlShadow;
		next_drvShadow = drvShadow;
		next_runQ = standbyN && !softStandby;
		if (regWrite && regAddr == 16'h3002) next_dirShadow = regWriteData;
		if (regWrite && regAddr == 16'h3008) next_srcShadow = regWriteData;
		if (regWrite && regAddr == 16'h3005) next_lvlShadow = regWriteData;
		if (regWrite && regAddr == 16'h3009) next_drvShadow = regWriteData;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dirShadow <= 8'h00;
			srcShadow <= 8'h00;
			lvlShadow <= 8'h00;
			drvShadow <= 8'h00;
			runQ <= 1'b0;
		end else begin
			dirShadow <= next_dirShadow;
			srcShadow <= next_srcShadow;
			lvlShadow <= next_lvlShadow;
			drvShadow <= next_drvShadow;
			runQ <= next_runQ;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_fs_input: assert property (!dirShadow[7] |=> !frameSyncPadOe)
		else $error("frame sync pad driven as input");
	a_fs_source: assert property (dirShadow[7] && runQ |=> frameSyncPadOe &&
		frameSyncPadOut == $past(srcShadow[7] ? lvlShadow[7] : vsyncPath))
		else $error("frame sync pad source wrong");
	a_line_source: assert property (dirShadow[6] && runQ |=>
		lineValidPadOut == $past(srcShadow[6] ? lvlShadow[6] : hsyncPath))
		else $error("line valid pad source wrong");
	a_expo_source: assert property (dirShadow[4] && runQ |=>
		exposureTriggerPadOut == $past(srcShadow[5] ? lvlShadow[4] : exposurePath))
		else $error("exposure pad source wrong");
	a_gpiob_source: assert property (dirShadow[1] && runQ |=>
		generalIoPadBOut == $past(srcShadow[1] ? lvlShadow[1] : gpioPathB))
		else $error("general pad b source wrong");
	a_lanes_release: assert property ($rose(resetn) |-> lanePadOe == 10'h000 ##1
		(lanePadOe == 10'h3FF && lanePadOut == 10'h3FF))
		else $error("lane pads wrong around reset");
	a_flash_release: assert property ($rose(resetn) |->
		flashTriggerPadOe && !flashTriggerPadOut)
		else $error("flash pad not low in reset");
	a_ref_clock: assert property (refClockInEnable == standbyN)
		else $error("reference clock enable wrong");
	a_drive_field: assert property ($stable(drvShadow) |-> driveStrength == drvShadow[6:5])
		else $error("drive strength wrong");

	c_fs_register: cover property (dirShadow[7] && srcShadow[7] && runQ);
	c_soft_standby: cover property (softStandby);
	c_hard_standby: cover property (!standbyN);
endmodule : spio_pad_monitor

bind spio_sensor_pad_io_control spio_pad_monitor mon (.clk, .resetn, .standbyN, .softStandby,
	.regAddr, .regWrite, .regWriteData, .driveStrength, .vsyncPath, .hsyncPath, .exposurePath,
	.gpioPathB, .frameSyncPadOut, .frameSyncPadOe, .lineValidPadOut, .exposureTriggerPadOut,
	.generalIoPadBOut, .flashTriggerPadOut, .flashTriggerPadOe, .lanePadOut, .lanePadOe,
	.refClockInEnable);

/* verification/spio_host_pads.sv */
`timescale 1ns/1ns

// ********************************
// Host side of the pads
// ********************************
module spio_host_pads
	import spio_pkg::*;
(
	input  logic [5:0] padOe,
	input  logic [5:0] padOut,
	input  logic [5:0] hostLevel,
	output logic [5:0] padLevel
);
	// Host lets go of a pad the sensor drives, no contention modelled
	assign padLevel = (padOe & padOut) | (~padOe & hostLevel);
endmodule : spio_host_pads

/* verification/tb_spio_sensor_pad_io_control.sv */
`timescale 1ns/1ns

// ********************************
// Pad control bench
// ********************************
module tb_spio_sensor_pad_io_control;
	import spio_pkg::*;
	logic clk = 0, resetn = 0, standbyN = 1, softStandby = 0, regWrite = 0, regRead = 0;
	spio_addr_type regAddr = 16'h0000;
	spio_byte_type regWriteData = 8'h00, regReadData;
	logic regReadValid, flOut, flOe, refEn, pwmOut, pwmOe;
	spio_drive_type driveStrength;
	logic [6:0] path = 7'h00;
	logic [5:0] hostLevel = 6'h00, padIn, padOut, padOe;
	logic [9:0] laneOut, laneOe;
	logic [12:0] e;
	logic [5:0] r;
	int fail_count = 0, total_checks = 0;
	spio_addr_type addrs [4] = '{16'h3002, 16'h3005, 16'h3008, 16'h3009};
	spio_byte_type masks [4] = '{8'hDB, 8'hDF, 8'hFB, 8'h60};
	spio_byte_type combo [4][3] = '{'{8'hFF, 8'h00, 8'h00}, '{8'hFF, 8'hFF, 8'hAA},
		'{8'hFF, 8'hFF, 8'h55}, '{8'h2C, 8'hFF, 8'hFF}};

	always #2 clk = ~clk;

	spio_sensor_pad_io_control uut (.clk, .resetn, .standbyN, .softStandby, .regAddr, .regWrite,
		.regRead, .regWriteData, .regReadData, .regReadValid, .driveStrength,
		.vsyncPath(path[6]), .hsyncPath(path[5]), .exposurePath(path[4]),
		.illuminationPath(path[3]), .gpioPathB(path[2]), .gpioPathA(path[1]), .flashPath(path[0]),
		.frameSyncPadIn(padIn[5]), .frameSyncPadOut(padOut[5]), .frameSyncPadOe(padOe[5]),
		.lineValidPadIn(padIn[4]), .lineValidPadOut(padOut[4]), .lineValidPadOe(padOe[4]),
		.exposureTriggerPadIn(padIn[3]), .exposureTriggerPadOut(padOut[3]),
		.exposureTriggerPadOe(padOe[3]), .frameSyncInPadIn(padIn[2]),
		.frameSyncInPadOut(padOut[2]), .frameSyncInPadOe(padOe[2]), .generalIoPadBIn(padIn[1]),
		.generalIoPadBOut(padOut[1]), .generalIoPadBOe(padOe[1]), .generalIoPadAIn(padIn[0]),
		.generalIoPadAOut(padOut[0]), .generalIoPadAOe(padOe[0]), .flashTriggerPadOut(flOut),
		.flashTriggerPadOe(flOe), .illuminationPwmPadOut(pwmOut), .illuminationPwmPadOe(pwmOe),
		.lanePadOut(laneOut), .lanePadOe(laneOe), .refClockInEnable(refEn));

	spio_host_pads host (.padOe, .padOut, .hostLevel, .padLevel(padIn));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input spio_addr_type a, input spio_byte_type d);
		@(negedge clk);
		regAddr = a;
		regWriteData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
	endtask : wr

	// Read data and its valid pulse land one edge after the strobe
	task automatic rd(input spio_addr_type a, input spio_byte_type x);
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		check({regReadValid, regReadData}, {1'b1, x});
	endtask : rd

	// Pad order fs, lv, exp, frame_sync_in_pad, gB, gA, then flash as bit 0
	function automatic logic [12:0] padExp(input spio_byte_type d, s, l, input logic [6:0] p);
		logic [6:0] dv, sv, lv;
		dv = {d[7], d[6], d[4], d[3], d[1], d[0], 1'b1};
		sv = {s[7], s[6], s[5], s[3], s[1], s[0], s[4]};
		lv = {l[7], l[6], l[4], l[3], l[1], l[0], l[2]};
		return {dv[6:1], dv & ((sv & lv) | (~sv & p))};
	endfunction : padExp

	task automatic check_defaults();
		for (int i = 0; i < 4; i++) begin
			rd(addrs[i], 8'h00);
		end
		rd(16'h30F0, 8'h01);
		rd(16'h1234, 8'h00);
		check({padOe, flOe, flOut, laneOe, laneOut}, {6'h00, 2'b10, 20'hFFFFF});
	endtask : check_defaults

	initial begin
		#80000;
		fail_count++;
		finish_test();
	end

	initial begin
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		check_defaults();
		for (int i = 0; i < 4; i++) begin
			wr(addrs[i], 8'hFF);
			rd(addrs[i], masks[i]);
			wr(16'h3009, 8'h9F | (i << 5));
			@(negedge clk);
			check(driveStrength, i);
		end
		for (int i = 0; i < 4; i++) begin
			wr(16'h3002, combo[i][0]);
			wr(16'h3008, combo[i][1]);
			wr(16'h3005, combo[i][2]);
			path = 7'h35 ^ (7'h0F << i);
			hostLevel = ~path[6:1];
			repeat (3) @(negedge clk);
			e = padExp(combo[i][0], combo[i][1], combo[i][2], path);
			check(padOe, e[12:7]);
			check(padOut, e[6:1]);
			check({flOut, pwmOe, pwmOut}, {e[0], 1'b1, path[3]});
			r = (e[12:7] & e[6:1]) | (~e[12:7] & hostLevel);
			rd(16'h30F1, {r[5], r[4], 1'b0, r[3], r[2], 1'b0, r[1], r[0]});
		end
		softStandby = 1'b1;
		repeat (3) @(negedge clk);
		check({padOe, flOut, pwmOut, laneOe, laneOut}, {8'h00, 20'hFFFFF});
		softStandby = 1'b0;
		standbyN = 1'b0;
		repeat (3) @(negedge clk);
		check({refEn, padOe, laneOe}, {7'h00, 10'h3FF});
		standbyN = 1'b1;
		repeat (3) @(negedge clk);
		rd(16'h3005, 8'hDF);
		check(padOe, 6'h04);
		wr(16'h30F0, 8'h00);
		standbyN = 1'b0;
		repeat (3) @(negedge clk);
		check(laneOe, 10'h000);
		standbyN = 1'b1;
		path = 7'h00;
		resetn = 1'b0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		check_defaults();
		finish_test();
	end
endmodule : tb_spio_sensor_pad_io_control
